/* core/dmm_pkg.sv */
// Constants and carrier types for the detection monitor output mux.
// Assumes a Wishbone classic slave with 32-bit data, 100 MHz clock.
// Overview of operation
// - Monitor selections act only in Run or Standby; Battery Saving drives both pins low.
// - Pin one source from select bits 6..4, pin two from bits 2..0.
// - Codes: 0 low, 1 detect, 2 preamble, 3 RSSI, 4 noise, 5 status, 6 no-signal, 7 lock.
// - Combined detect follows preamble when enabled, else noise or RSSI.
// - Hold-enable bit set latches combined detect high after first detection.
// - Latched combined detect clears only on entering Battery Saving or Standby.
// - Preamble monitor output follows the preamble detector result.
// - RSSI monitor output follows the RSSI detector result.
// - Noise monitor output follows the noise detector result.
// - Status output low in Battery Saving, high in Standby or Run.
// - Lock output high while synthesizer lock detector reports lock.
// - No-signal: preamble high wins; else noise-off follows RSSI; noise high needs RSSI high/off.
package dmm_pkg;

   localparam logic [7:0] SELECT_OFFSET   = 8'h14;
   localparam logic [7:0] HOLD_OFFSET     = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFFSET = 8'h20;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h24;
   localparam logic [7:0] STATE_OFFSET    = 8'h28;

   localparam int PIN_ONE_SEL_LSB = 4;
   localparam int PIN_TWO_SEL_LSB = 0;
   localparam int HOLD_BIT        = 2;

   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET   = 8'h00;
   localparam logic [3:0] IRQ_RESET    = 4'h0;

   // Interrupt status bits
   localparam int IRQ_DETECT   = 0;
   localparam int IRQ_NOSIG    = 1;
   localparam int IRQ_LOCKLOSS = 2;
   localparam int IRQ_STATE    = 3;

   typedef enum logic [1:0] {
      POWER_SAVE    = 2'h0,
      POWER_STANDBY = 2'h1,
      POWER_RUN     = 2'h2
   } dmm_power_type;

   typedef enum logic [2:0] {
      SRC_LOW      = 3'h0,
      SRC_DETECT   = 3'h1,
      SRC_PREAMBLE = 3'h2,
      SRC_RSSI     = 3'h3,
      SRC_NOISE    = 3'h4,
      SRC_STATUS   = 3'h5,
      SRC_NOSIGNAL = 3'h6,
      SRC_LOCK     = 3'h7
   } dmm_source_type;

   // Each detector: result plus an enable; disabled means the table's OFF
   typedef struct packed {
      logic preambleOn;
      logic preambleResult;
      logic rssiOn;
      logic rssiResult;
      logic noiseOn;
      logic noiseResult;
   } dmm_detect_type;

   typedef struct packed {
      logic combinedDetect;
      logic preamble;
      logic rssi;
      logic noise;
      logic powerState;
      logic noSignal;
      logic synthLock;
   } dmm_sources_type;

endpackage

/* core/dmm_pin_select.sv */
// One monitor pin: picks a source by code and registers the pin.
// Assumes sources are synchronous to clk.
`timescale 1ns/100ps
module dmm_pin_select (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rstn,
   // Control
   input  wire logic                     active,
   input  wire dmm_pkg::dmm_source_type  sel,
   input  wire dmm_pkg::dmm_sources_type src,
   // Pin
   output logic                          pin
);

   logic next_pin;

   always_comb begin
      case (sel)
         dmm_pkg::SRC_LOW:      next_pin = 1'b0;
         dmm_pkg::SRC_DETECT:   next_pin = src.combinedDetect;
         dmm_pkg::SRC_PREAMBLE: next_pin = src.preamble;
         dmm_pkg::SRC_RSSI:     next_pin = src.rssi;
         dmm_pkg::SRC_NOISE:    next_pin = src.noise;
         dmm_pkg::SRC_STATUS:   next_pin = src.powerState;
         dmm_pkg::SRC_NOSIGNAL: next_pin = src.noSignal;
         dmm_pkg::SRC_LOCK:     next_pin = src.synthLock;
         default:               next_pin = 1'b0;
      endcase
   end

   // Registered so a select change cannot glitch the pin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin <= 1'b0;
      end else begin
         pin <= active & next_pin;
      end
   end

endmodule // dmm_pin_select

/* core/dmm_monitor_mux.sv */
// Top of the detection monitor output mux with Wishbone register slave.
// Assumes detector, lock and power-state inputs are on clk.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module dmm_monitor_mux (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // Wishbone classic slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // Receiver status
   input  wire dmm_pkg::dmm_detect_type detect,
   input  wire logic                    synth_lock_indicator,
   input  wire dmm_pkg::dmm_power_type  powerState,
   // Monitor pins and interrupt
   output logic                         monitor_pin_one,
   output logic                         monitor_pin_two,
   output logic                         irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]                monitor_pin_source_select;
   logic                      detect_hold_enable;
   logic [3:0]                irqStatus;
   logic [3:0]                irqMask;
   logic                      combinedHeld;
   logic                      combined_signal_detect;
   logic                      combined_no_signal_detect;
   logic                      rawDetect;
   logic                      power_state_indicator;
   logic                      active;
   logic                      prevDetect;
   logic                      prevNoSig;
   logic                      prevLock;
   dmm_pkg::dmm_power_type    prevPower;
   dmm_pkg::dmm_sources_type  sources;
   logic                      wbAccess;
   logic                      wbWrite;
   logic                      leaveRun;
   logic [3:0]                events;

   assign wbAccess = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wbWrite  = wbAccess & wb_we_i & wb_sel_i[0];

   ////////////////////////////////////////////////////////////////////////////
   // Power state decode
   assign active = (powerState == dmm_pkg::POWER_RUN)
                 | (powerState == dmm_pkg::POWER_STANDBY);
   assign power_state_indicator = active;
   assign leaveRun = (powerState != dmm_pkg::POWER_RUN)
                   & (prevPower == dmm_pkg::POWER_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Combined detect: OFF detectors contribute nothing
   always_comb begin
      if (detect.preambleOn) begin
         rawDetect = detect.preambleResult;
      end else begin
         rawDetect = (detect.noiseOn & detect.noiseResult)
                   | (detect.rssiOn & detect.rssiResult);
      end
   end

   // Hold latch; cleared on the move into Standby or Battery Saving
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         combinedHeld <= 1'b0;
      end else if (leaveRun || !active) begin
         combinedHeld <= 1'b0;
      end else if (detect_hold_enable && rawDetect) begin
         combinedHeld <= 1'b1;
      end
   end

   assign combined_signal_detect = rawDetect | (detect_hold_enable & combinedHeld);

   // No-signal judgement
   always_comb begin
      if (detect.preambleOn && detect.preambleResult) begin
         combined_no_signal_detect = 1'b1;
      end else if (!detect.noiseOn) begin
         combined_no_signal_detect = detect.rssiOn & detect.rssiResult;
      end else if (detect.noiseResult) begin
         combined_no_signal_detect = ~detect.rssiOn | detect.rssiResult;
      end else begin
         combined_no_signal_detect = 1'b0;
      end
   end

   always_comb begin
      sources.combinedDetect = combined_signal_detect;
      sources.preamble       = detect.preambleOn & detect.preambleResult;
      sources.rssi           = detect.rssiOn & detect.rssiResult;
      sources.noise          = detect.noiseOn & detect.noiseResult;
      sources.powerState     = power_state_indicator;
      sources.noSignal       = combined_no_signal_detect;
      sources.synthLock      = synth_lock_indicator;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin selectors
   dmm_pin_select pinOne (
      .clk  (clk),
      .rstn (rstn),
      .active (active),
      .sel  (dmm_pkg::dmm_source_type'(monitor_pin_source_select[
                dmm_pkg::PIN_ONE_SEL_LSB +: 3])),
      .src  (sources),
      .pin  (monitor_pin_one)
   );

   dmm_pin_select pinTwo (
      .clk  (clk),
      .rstn (rstn),
      .active (active),
      .sel  (dmm_pkg::dmm_source_type'(monitor_pin_source_select[
                dmm_pkg::PIN_TWO_SEL_LSB +: 3])),
      .src  (sources),
      .pin  (monitor_pin_two)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         monitor_pin_source_select <= dmm_pkg::SELECT_RESET;
      end else if (wbWrite && wb_adr_i == dmm_pkg::SELECT_OFFSET) begin
         monitor_pin_source_select <= {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         detect_hold_enable <= 1'b0;
      end else if (wbWrite && wb_adr_i == dmm_pkg::HOLD_OFFSET) begin
         detect_hold_enable <= wb_dat_i[dmm_pkg::HOLD_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqMask <= dmm_pkg::IRQ_RESET;
      end else if (wbWrite && wb_adr_i == dmm_pkg::IRQ_MASK_OFFSET) begin
         irqMask <= wb_dat_i[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events: rise of detect, rise of no-signal, loss of lock, state change
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prevDetect <= 1'b0;
         prevNoSig  <= 1'b0;
         prevLock   <= 1'b0;
         prevPower  <= dmm_pkg::POWER_SAVE;
      end else begin
         prevDetect <= combined_signal_detect;
         prevNoSig  <= combined_no_signal_detect;
         prevLock   <= synth_lock_indicator;
         prevPower  <= powerState;
      end
   end

   always_comb begin
      events = 4'h0;
      events[dmm_pkg::IRQ_DETECT]   = combined_signal_detect & ~prevDetect;
      events[dmm_pkg::IRQ_NOSIG]    = combined_no_signal_detect & ~prevNoSig;
      events[dmm_pkg::IRQ_LOCKLOSS] = prevLock & ~synth_lock_indicator;
      events[dmm_pkg::IRQ_STATE]    = powerState != prevPower;
   end

   // Set wins over a same-cycle write-one-to-clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqStatus <= dmm_pkg::IRQ_RESET;
      end else if (wbWrite && wb_adr_i == dmm_pkg::IRQ_STAT_OFFSET) begin
         irqStatus <= (irqStatus & ~wb_dat_i[3:0]) | events;
      end else begin
         irqStatus <= irqStatus | events;
      end
   end

   assign irq = |(irqStatus & irqMask);

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: one registered ack the cycle after the request, unmapped reads return zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wbAccess;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wbAccess && !wb_we_i) begin
         case (wb_adr_i)
            dmm_pkg::SELECT_OFFSET:   wb_dat_o <= {24'h000000, monitor_pin_source_select};
            dmm_pkg::HOLD_OFFSET:     wb_dat_o <= {29'h0000000, detect_hold_enable, 2'h0};
            dmm_pkg::IRQ_STAT_OFFSET: wb_dat_o <= {28'h0000000, irqStatus};
            dmm_pkg::IRQ_MASK_OFFSET: wb_dat_o <= {28'h0000000, irqMask};
            dmm_pkg::STATE_OFFSET:    wb_dat_o <= {25'h000000, combined_no_signal_detect,
                                                   combined_signal_detect, monitor_pin_two,
                                                   monitor_pin_one, synth_lock_indicator,
                                                   powerState};
            default:                  wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

endmodule // dmm_monitor_mux

/* sim/dmm_monitor_mux_assertions.sv */
// Checker for the monitor mux top ports.
// Assumes it is bound onto dmm_monitor_mux; one clock domain.
`timescale 1ns/100ps
module dmm_monitor_mux_assertions (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rstn,
   // Bus
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_we_i,
   input wire logic [7:0]              wb_adr_i,
   input wire logic [3:0]              wb_sel_i,
   input wire logic [31:0]             wb_dat_i,
   input wire logic                    wb_ack_o,
   // Status and pins
   input wire dmm_pkg::dmm_detect_type detect,
   input wire logic                    synth_lock_indicator,
   input wire dmm_pkg::dmm_power_type  powerState,
   input wire logic                    monitor_pin_one,
   input wire logic                    monitor_pin_two
);
   logic [7:0] selReg;
   logic       act;
   logic [2:0] s1;
   logic [2:0] s2;
   assign act = powerState == dmm_pkg::POWER_STANDBY || powerState == dmm_pkg::POWER_RUN;
   assign s1 = selReg[6:4];
   assign s2 = selReg[2:0];
   // Mirror of the select register; the register itself is not a port this checker sees
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) selReg <= 8'h00;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] &&
               wb_adr_i == dmm_pkg::SELECT_OFFSET) selReg <= wb_dat_i[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   property p_off; !act |=> !monitor_pin_one && !monitor_pin_two; endproperty
   a_off: assert property (p_off) else $error("pin high while inactive");
   property p_same; act && s1 == s2 |=> monitor_pin_one == monitor_pin_two; endproperty
   a_same: assert property (p_same) else $error("pins differ on one source");
   property p_low; act && s2 == 3'h0 |=> !monitor_pin_two; endproperty
   a_low: assert property (p_low) else $error("code zero not low");
   property p_det; act && s2 == 3'h1 && !detect.preambleOn && detect.noiseOn &&
      detect.noiseResult |=> monitor_pin_two; endproperty
   a_det: assert property (p_det) else $error("combined detect missed noise");
   property p_pre; act && s2 == 3'h2 && detect.preambleOn |=>
      monitor_pin_two == $past(detect.preambleResult); endproperty
   a_pre: assert property (p_pre) else $error("preamble pin wrong");
   property p_rssi; act && s1 == 3'h3 && detect.rssiOn && detect.rssiResult |=>
      monitor_pin_one; endproperty
   a_rssi: assert property (p_rssi) else $error("rssi pin low");
   property p_stat; act && s2 == 3'h5 |=> monitor_pin_two; endproperty
   a_stat: assert property (p_stat) else $error("status pin low");
   property p_lock; act && s1 == 3'h7 |=> monitor_pin_one == $past(synth_lock_indicator);
   endproperty
   a_lock: assert property (p_lock) else $error("lock pin wrong");
   c_lock: cover property (act && s1 == 3'h7 ##1 monitor_pin_one);
   c_wake: cover property (!act ##1 act);
   c_det: cover property (act && s2 == 3'h1 ##1 monitor_pin_two);
endmodule // dmm_monitor_mux_assertions

bind dmm_monitor_mux dmm_monitor_mux_assertions u_dmm_monitor_mux_assertions (
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .detect(detect), .synth_lock_indicator(synth_lock_indicator), .powerState(powerState),
   .monitor_pin_one(monitor_pin_one), .monitor_pin_two(monitor_pin_two));

/* sim/dmm_host_model.sv */
// Host microcontroller model sampling the monitor pins and interrupt.
// Assumes the lines are settled before each rising clk edge.
`timescale 1ns/100ps
module dmm_host_model (
   // Clock
   input  wire logic       clk,
   // Watched lines
   input  wire logic       pinOne,
   input  wire logic       pinTwo,
   input  wire logic       irqLine,
   // Captured levels
   output logic      [2:0] seen
);
   // A real host sees levels only at its own sample edge, one cycle late
   always @(posedge clk) seen <= {irqLine, pinOne, pinTwo};
endmodule // dmm_host_model

/* sim/tb.sv */
// Self-checking bench for the detection monitor output mux.
// Assumes package, design, host model and checker compiled before it.
`timescale 1ns/100ps
module tb;
   logic                    clk = 1'h0;
   logic                    rstn = 1'h0;
   logic                    cyc = 1'h0;
   logic                    stb = 1'h0;
   logic                    we = 1'h0;
   logic [3:0]              sel = 4'h0;
   logic [3:0]              selMask = 4'hF;
   logic [7:0]              adr = 8'h00;
   logic [31:0]             wdat = 32'h0;
   logic [31:0]             rdat;
   logic                    ack, pinOne, pinTwo, irq;
   logic                    lock = 1'h0;
   logic [2:0]              seen;
   dmm_pkg::dmm_detect_type det = 6'h00;
   dmm_pkg::dmm_power_type  ps = dmm_pkg::POWER_SAVE;
   int                      n_fail = 0;
   int                      checks = 0;
   logic [31:0]             rq[$];
   logic [2:0]              pq[$];
   always #5 clk = ~clk;
   dmm_monitor_mux u_dmm_monitor_mux (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .detect(det), .synth_lock_indicator(lock), .powerState(ps),
      .monitor_pin_one(pinOne), .monitor_pin_two(pinTwo), .irq(irq));
   dmm_host_model u_dmm_host_model (.clk(clk), .pinOne(pinOne), .pinTwo(pinTwo),
      .irqLine(irq), .seen(seen));
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      // Notes left on a queue mean an answer never came
      if (rq.size() > 0 || pq.size() > 0) begin
         n_fail++;
         $display("unexpected at %0t: %0d notes never compared", $time, rq.size() + pq.size());
      end
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp_dat(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: read %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [2:0] got, input logic [2:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: irq/pins %b want %b", $time, got, exp);
      end
   endtask
   always @(posedge clk) if (ack && !we && rq.size() > 0) cmp_dat(rdat, rq.pop_front());
   always @(negedge clk) if (pq.size() > 0) cmp_pin(seen, pq.pop_front());
   // Classic cycle: hold everything until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      sel <= selMask;
      adr <= a;
      wdat <= d;
      for (int i = 0; i < 20 && ack !== 1'h1; i++) @(posedge clk);
      if (ack !== 1'h1) begin
         n_fail++;
         $display("unexpected at %0t: no ack", $time);
         stop_test();
      end
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      sel <= 4'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'h0, a, 32'h0);
   endtask
   // Host captures one edge after the pin, so wait one extra edge
   task automatic chk(input logic [2:0] e, input int n);
      repeat (n + 1) @(posedge clk);
      pq.push_back(e);
   endtask
   function automatic logic lvl(input logic [2:0] c, input dmm_pkg::dmm_detect_type d,
                                input logic l, input dmm_pkg::dmm_power_type p);
      logic pre, rs, no;
      pre = d.preambleOn & d.preambleResult;
      rs = d.rssiOn & d.rssiResult;
      no = d.noiseOn & d.noiseResult;
      if (p != dmm_pkg::POWER_STANDBY && p != dmm_pkg::POWER_RUN) return 1'h0;
      case (c)
         3'h1: return d.preambleOn ? d.preambleResult : (no | rs);
         3'h2: return pre;
         3'h3: return rs;
         3'h4: return no;
         3'h5: return 1'h1;
         3'h6: return pre | (d.noiseOn ? d.noiseResult & (rs | !d.rssiOn) : rs);
         3'h7: return l;
         default: return 1'h0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] s;
      dmm_pkg::dmm_detect_type d;
      logic l;
      dmm_pkg::dmm_power_type p;
      s = 8'($urandom(32'h10C7F608));
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      rd(dmm_pkg::SELECT_OFFSET, 32'h0);
      rd(dmm_pkg::HOLD_OFFSET, 32'h0);
      wb(1'h1, dmm_pkg::SELECT_OFFSET, 32'hFF);
      rd(dmm_pkg::SELECT_OFFSET, 32'h77);
      wb(1'h1, 8'h3C, 32'hFF);
      rd(8'h3C, 32'h0);
      // Byte lane 0 off: the write must be ignored
      selMask = 4'hE;
      wb(1'h1, dmm_pkg::SELECT_OFFSET, 32'h00);
      selMask = 4'hF;
      rd(dmm_pkg::SELECT_OFFSET, 32'h77);
      $display("test registers done");
      wb(1'h1, dmm_pkg::IRQ_MASK_OFFSET, 32'h8);
      wb(1'h1, dmm_pkg::SELECT_OFFSET, 32'h57);
      ps <= dmm_pkg::POWER_RUN;
      lock <= 1'h1;
      chk(3'h7, 2);
      rd(dmm_pkg::IRQ_STAT_OFFSET, 32'h8);
      rd(dmm_pkg::STATE_OFFSET, 32'h1E);
      wb(1'h1, dmm_pkg::IRQ_STAT_OFFSET, 32'h8);
      chk(3'h3, 1);
      ps <= dmm_pkg::POWER_SAVE;
      chk(3'h4, 2);
      wb(1'h1, dmm_pkg::IRQ_MASK_OFFSET, 32'h0);
      chk(3'h0, 1);
      lock <= 1'h0;
      rd(dmm_pkg::IRQ_STAT_OFFSET, 32'hC);
      wb(1'h1, dmm_pkg::IRQ_STAT_OFFSET, 32'hF);
      $display("test interrupt done");
      for (int i = 0; i < 64; i++) begin
         s = {1'h0, 3'(i), 1'h0, 3'(i >> 3)};
         d = 6'($urandom);
         l = 1'($urandom);
         p = dmm_pkg::dmm_power_type'(2'($urandom % 3));
         wb(1'h1, dmm_pkg::SELECT_OFFSET, {24'h0, s});
         det <= d;
         lock <= l;
         ps <= p;
         chk({1'h0, lvl(s[6:4], d, l, p), lvl(s[2:0], d, l, p)}, 1);
      end
      $display("test sources done");
      wb(1'h1, dmm_pkg::HOLD_OFFSET, 32'h4);
      wb(1'h1, dmm_pkg::SELECT_OFFSET, 32'h11);
      ps <= dmm_pkg::POWER_RUN;
      det <= 6'h03;
      chk(3'h3, 1);
      det <= 6'h02;
      chk(3'h3, 2);
      ps <= dmm_pkg::POWER_STANDBY;
      chk(3'h0, 2);
      $display("test hold done");
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule // tb
